// file: logic/otp_isp.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module otp_isp
#(
    parameter int ADDR_W = 13,
    parameter logic [7:0] ID_VAL0 = 8'ha5, // Arbitrary identification value.
    parameter logic [7:0] ID_VAL1 = 8'h5a  // Arbitrary identification value.
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic coreIdle,
    input wire logic highVoltagePin,
    input wire logic i2cAddrMatch,
    output logic ispIrq,
    output logic transparentBlock,
    output logic staticReadMode,
    output logic progPulse,
    output logic fetchAvailable
);
    // The address pair is 16 bits wide and the id decode needs a whole low byte.
    if (ADDR_W < 8 || ADDR_W > 16)
    begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end

    logic highVoltagePresent;
    logic [7:0] ctrl_q;
    logic [7:0] data_q;
    logic [7:0] addrHigh_q;
    logic [7:0] addrLow_q;
    logic [7:0] test_q;
    logic ack_q;
    logic [31:0] rdat_q;
    otp_pkg::otp_state_t state_q;
    logic [7:0] verifyCnt_q;
    logic [1:0] latCnt_q;
    logic memWrite;
    logic [7:0] memRdData;
    logic [ADDR_W-1:0] memAddr;
    logic inMode;
    logic writeEnable;
    logic idEnable;
    logic [15:0] fullAddr;

    otp_sync u_hv_sync
    (
        .clk(clk),
        .arst_n(arst_n),
        .din(highVoltagePin),
        .dout(highVoltagePresent)
    );

    function automatic logic busHit(input logic [7:0] adr, input logic [7:0] reg_adr);
        busHit = (adr == reg_adr);
    endfunction

    logic busReq;
    logic busWr;
    assign busReq = wb_cyc_i && wb_stb_i && !ack_q;
    // A write lands at the edge where the master samples ack high.
    assign busWr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    assign inMode = ctrl_q[otp_pkg::BIT_MODE];
    assign writeEnable = ctrl_q[otp_pkg::BIT_WE];
    assign idEnable = ctrl_q[otp_pkg::BIT_SIG];
    assign fullAddr = {addrHigh_q, addrLow_q};
    assign memAddr = fullAddr[ADDR_W-1:0];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ack_q <= 1'b0;
        else
            ack_q <= busReq;
    end

    function automatic logic [7:0] idByte(input logic [7:0] a);
        if (a == otp_pkg::ID_ADDR0)
            idByte = ID_VAL0;
        else if (a == otp_pkg::ID_ADDR1)
            idByte = ID_VAL1;
        else if (a == otp_pkg::ID_ADDR2)
            idByte = otp_pkg::ID_VAL2;
        else
            idByte = 8'hff;
    endfunction

    // Register reads; the status bit shows the synchronized and filtered voltage level.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdat_q <= 32'h0;
        else if (busReq && !wb_we_i)
        begin
            rdat_q <= 32'h0;
            if (busHit(wb_adr_i, otp_pkg::ADDR_CTRL))
                rdat_q[7:0] <= {3'h0, highVoltagePresent, 1'b0, ctrl_q[2:0]};
            else if (busHit(wb_adr_i, otp_pkg::ADDR_DATA))
                rdat_q[7:0] <= data_q;
            else if (busHit(wb_adr_i, otp_pkg::ADDR_AH))
                rdat_q[7:0] <= addrHigh_q;
            else if (busHit(wb_adr_i, otp_pkg::ADDR_AL))
                rdat_q[7:0] <= addrLow_q;
            else if (busHit(wb_adr_i, otp_pkg::ADDR_TEST))
                rdat_q[7:0] <= test_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_q <= 8'h00;
        else if (busWr && busHit(wb_adr_i, otp_pkg::ADDR_CTRL))
            ctrl_q <= wb_dat_i[7:0] & otp_pkg::CTRL_WMASK;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addrHigh_q <= 8'h00;
            addrLow_q <= 8'h00;
        end
        else if (busWr && busHit(wb_adr_i, otp_pkg::ADDR_AH))
            addrHigh_q <= wb_dat_i[7:0];
        else if (busWr && busHit(wb_adr_i, otp_pkg::ADDR_AL))
            addrLow_q <= wb_dat_i[7:0];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            test_q <= otp_pkg::TEST_NORMAL;
        else if (busWr && busHit(wb_adr_i, otp_pkg::ADDR_TEST))
            test_q <= wb_dat_i[7:0];
    end
    assign staticReadMode = (test_q == otp_pkg::TEST_STATIC);

    // Program and verify sequencing on the core idle level.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= otp_pkg::ST_IDLE;
        else
        begin
            unique case (state_q)
                otp_pkg::ST_IDLE:
                    if (coreIdle && inMode)
                        state_q <= writeEnable ? otp_pkg::ST_PROG : otp_pkg::ST_VERIFY;
                otp_pkg::ST_PROG:
                    if (!coreIdle)
                        state_q <= otp_pkg::ST_IDLE;
                otp_pkg::ST_VERIFY:
                    if (latCnt_q == otp_pkg::MEM_READ_LAT)
                        state_q <= otp_pkg::ST_DONE;
                otp_pkg::ST_DONE:
                    if (!coreIdle)
                        state_q <= otp_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            latCnt_q <= 2'h0;
        else if (state_q == otp_pkg::ST_VERIFY)
            latCnt_q <= latCnt_q + 2'h1;
        else
            latCnt_q <= 2'h0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            verifyCnt_q <= 8'h00;
        else if (state_q == otp_pkg::ST_IDLE)
            verifyCnt_q <= 8'h00;
        else if (verifyCnt_q != 8'hff)
            verifyCnt_q <= verifyCnt_q + 8'h01;
    end

    // Data register: bus writes, or the verify result at the end of the read.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            data_q <= otp_pkg::DATA_RESET;
        else if (state_q == otp_pkg::ST_VERIFY && latCnt_q == otp_pkg::MEM_READ_LAT)
            data_q <= idEnable ? idByte(addrLow_q) : memRdData;
        else if (busWr && busHit(wb_adr_i, otp_pkg::ADDR_DATA))
            data_q <= wb_dat_i[7:0];
    end

    assign progPulse = (state_q == otp_pkg::ST_PROG) && coreIdle && inMode && writeEnable
                       && highVoltagePresent && !idEnable;
    assign memWrite = progPulse;
    assign fetchAvailable = (state_q == otp_pkg::ST_IDLE);
    assign transparentBlock = inMode;
    assign ispIrq = i2cAddrMatch;

    otp_mem #(.ADDR_W(ADDR_W)) u_mem
    (
        .clk(clk),
        .arst_n(arst_n),
        .addr(memAddr),
        .wrEn(memWrite),
        .wrData(data_q),
        .rdData(memRdData)
    );

    // Checks on the programming gate, the sequencer, the register bus and the interrupt request.
    a_pulse_gated: assert property (@(posedge clk) disable iff (!arst_n)
        progPulse |-> (inMode && writeEnable && highVoltagePresent))
        else $error("programming pulse without enables");
    a_verify_no_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == otp_pkg::ST_VERIFY) |-> !progPulse)
        else $error("pulse during verify");
    a_verify_latch: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == otp_pkg::ST_VERIFY && latCnt_q == otp_pkg::MEM_READ_LAT && !idEnable)
        |=> (data_q == $past(memRdData)))
        else $error("verify byte not latched");
    a_verify_bound: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == otp_pkg::ST_IDLE && coreIdle && inMode && !writeEnable)
        |=> ##[1:3] (state_q == otp_pkg::ST_DONE))
        else $error("verify read did not finish");
    // The verify read must end well inside the shortest timer period that software may set.
    a_verify_time: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == otp_pkg::ST_VERIFY) |-> (verifyCnt_q < 8'(otp_pkg::VERIFY_CYC)))
        else $error("verify read outlasts the shortest timer");
    a_prog_entry: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == otp_pkg::ST_IDLE && coreIdle && inMode && writeEnable)
        |=> (state_q == otp_pkg::ST_PROG))
        else $error("program cycle not started");
    a_prog_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == otp_pkg::ST_PROG && coreIdle) |=> (state_q == otp_pkg::ST_PROG))
        else $error("program cycle ended while idle");
    a_mode_refused: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == otp_pkg::ST_IDLE && !inMode) |=> (state_q == otp_pkg::ST_IDLE))
        else $error("sequencer left idle outside the mode");
    a_id_no_write: assert property (@(posedge clk) disable iff (!arst_n)
        idEnable |-> !memWrite)
        else $error("write pulse with id bytes enabled");
    a_fetch_back: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q != otp_pkg::ST_IDLE && !coreIdle && state_q != otp_pkg::ST_VERIFY)
        |=> fetchAvailable)
        else $error("fetch not restored");
    a_static_read: assert property (@(posedge clk) disable iff (!arst_n)
        (busWr && busHit(wb_adr_i, otp_pkg::ADDR_TEST) && wb_dat_i[7:0] == otp_pkg::TEST_STATIC)
        |=> staticReadMode)
        else $error("static read not entered");
    a_ctrl_reserved: assert property (@(posedge clk) disable iff (!arst_n)
        ctrl_q[7:3] == 5'h0)
        else $error("reserved control bits set");
    a_hv_read: assert property (@(posedge clk) disable iff (!arst_n)
        (busReq && !wb_we_i && busHit(wb_adr_i, otp_pkg::ADDR_CTRL))
        |=> (wb_dat_o[otp_pkg::BIT_HIGH_VOLTAGE_PRESENT] == $past(highVoltagePresent)))
        else $error("voltage status not shown");
    a_irq_follow: assert property (@(posedge clk) disable iff (!arst_n)
        i2cAddrMatch |-> ispIrq)
        else $error("interrupt request missing");
    a_ack_answer: assert property (@(posedge clk) disable iff (!arst_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_single: assert property (@(posedge clk) disable iff (!arst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule // otp_isp
`default_nettype wire

// file: logic/otp_pkg.sv
`default_nettype none
package otp_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'hdc;
    localparam logic [7:0] ADDR_DATA = 8'hd8;
    localparam logic [7:0] ADDR_AH = 8'hd9;
    localparam logic [7:0] ADDR_AL = 8'hda;
    localparam logic [7:0] ADDR_TEST = 8'hdb;
    localparam int BIT_HIGH_VOLTAGE_PRESENT = 4;
    localparam int BIT_SIG = 2;
    localparam int BIT_WE = 1;
    localparam int BIT_MODE = 0;
    localparam logic [7:0] CTRL_WMASK = 8'h07;
    localparam logic [7:0] TEST_STATIC = 8'h08;
    localparam logic [7:0] TEST_NORMAL = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'hff;
    localparam logic [7:0] ID_ADDR0 = 8'h30;
    localparam logic [7:0] ID_ADDR1 = 8'h31;
    localparam logic [7:0] ID_ADDR2 = 8'h60;
    localparam logic [7:0] ID_VAL2 = 8'h00;
    localparam int CLK_MHZ = 20;
    localparam int VERIFY_MIN_NS = 1000;
    localparam int VERIFY_CYC = (VERIFY_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0] MEM_READ_LAT = 2'h1;
    typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_VERIFY, ST_DONE} otp_state_t;
endpackage
`default_nettype wire

// file: logic/otp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module otp_sync
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic din,
    output logic dout
);
    logic [2:0] stage_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            stage_q <= 3'h0;
        else
            stage_q <= {stage_q[1:0], din};
    end
    // The output moves only when the second and third stages agree.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            dout <= 1'b0;
        else if (stage_q[1] == stage_q[2])
            dout <= stage_q[2];
    end
endmodule // otp_sync
`default_nettype wire

// file: logic/otp_mem.sv
`timescale 1ns/1ps
`default_nettype none
module otp_mem
#(
    parameter int ADDR_W = 13
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData
);
    if (ADDR_W < 1 || ADDR_W > 16)
    begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end
    logic [7:0] cells [0:(1<<ADDR_W)-1];
    // Unprogrammed cells read as all ones; a write can only clear bits.
    always_ff @(posedge clk)
    begin
        if (wrEn)
            cells[addr] <= cells[addr] & wrData;
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdData <= 8'h00;
        else
            rdData <= cells[addr];
    end
    initial
    begin
        for (int i = 0; i < (1<<ADDR_W); i++)
            cells[i] = 8'hff;
    end
endmodule // otp_mem
`default_nettype wire

// file: dv/otp_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// The far side: a programming voltage source and an external I2C master.
module otp_far_model
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hvEnable,
    input wire logic addrHit,
    output logic highVoltagePin,
    output logic i2cAddrMatch
);
    // The source only switches on command; the bench holds it steady across a mode session.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            highVoltagePin <= 1'b0;
            i2cAddrMatch <= 1'b0;
        end
        else
        begin
            highVoltagePin <= hvEnable;
            i2cAddrMatch <= addrHit;
        end
    end
endmodule // otp_far_model
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, coreIdle = 1'b0, hvEnable = 1'b0, addrHit = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h1;
    logic [31:0] datI = 32'h0, datO, rd;
    logic ack, hvPin, match, ispIrq, transparentBlock, staticReadMode, progPulse, fetchAvailable;
    logic [7:0] shadow [int];
    logic [12:0] a;
    logic [7:0] d;
    int mismatches = 0, total_checks = 0;

    always #25 clk = ~clk;

    otp_isp uut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .coreIdle(coreIdle),
        .highVoltagePin(hvPin), .i2cAddrMatch(match), .ispIrq(ispIrq), .transparentBlock(transparentBlock),
        .staticReadMode(staticReadMode), .progPulse(progPulse), .fetchAvailable(fetchAvailable));
    otp_far_model far (.clk(clk), .arst_n(arst_n), .hvEnable(hvEnable), .addrHit(addrHit),
        .highVoltagePin(hvPin), .i2cAddrMatch(match));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic single cycle; the request stands until ack is sampled high.
    task automatic wbCycle(input logic w, input logic [7:0] ad, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        datI <= {24'h0, wd};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
        begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic readCheck(input logic [7:0] ad, input logic [7:0] exp);
        wbCycle(1'b0, ad, 8'h00);
        check(rd, {24'h0, exp});
    endtask

    task automatic runIdle(input logic expPulse, input logic expFetch);
        @(posedge clk);
        coreIdle <= 1'b1;
        repeat (4) @(posedge clk);
        check(32'(progPulse), 32'(expPulse));
        check(32'(fetchAvailable), 32'(expFetch));
        coreIdle <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'(fetchAvailable), 32'h1);
    endtask

    task automatic setAddr(input logic [12:0] ad);
        wbCycle(1'b1, otp_pkg::ADDR_AH, {3'h0, ad[12:8]});
        wbCycle(1'b1, otp_pkg::ADDR_AL, ad[7:0]);
    endtask

    task automatic progByte(input logic [12:0] ad, input logic [7:0] wd, input logic [7:0] ctrl, input logic p);
        setAddr(ad);
        wbCycle(1'b1, otp_pkg::ADDR_DATA, wd);
        wbCycle(1'b1, otp_pkg::ADDR_CTRL, ctrl);
        runIdle(p, 1'b0);
    endtask

    // Preloading all ones exposes a verify that never latches.
    task automatic verify(input logic [12:0] ad, input logic [7:0] ctrl, input logic [7:0] exp);
        setAddr(ad);
        wbCycle(1'b1, otp_pkg::ADDR_CTRL, ctrl);
        wbCycle(1'b1, otp_pkg::ADDR_DATA, 8'hff);
        runIdle(1'b0, 1'b0);
        wbCycle(1'b0, otp_pkg::ADDR_DATA, 8'h00);
        check(rd, {24'h0, exp});
    endtask

    function automatic logic [7:0] expAnd(input logic [12:0] ad, input logic [7:0] wd);
        return (shadow.exists(int'(ad)) ? shadow[int'(ad)] : 8'hff) & wd;
    endfunction

    initial
    begin
        void'($urandom(47471));
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        readCheck(otp_pkg::ADDR_CTRL, 8'h00);
        readCheck(otp_pkg::ADDR_DATA, 8'hff);
        readCheck(8'h00, 8'h00);
        wbCycle(1'b1, otp_pkg::ADDR_CTRL, 8'hff);
        readCheck(otp_pkg::ADDR_CTRL, 8'h07);
        check(32'(transparentBlock), 32'h1);
        $display("registers done");
        wbCycle(1'b1, otp_pkg::ADDR_TEST, otp_pkg::TEST_STATIC);
        readCheck(otp_pkg::ADDR_TEST, otp_pkg::TEST_STATIC);
        check(32'(staticReadMode), 32'h1);
        wbCycle(1'b1, otp_pkg::ADDR_TEST, otp_pkg::TEST_NORMAL);
        readCheck(otp_pkg::ADDR_TEST, otp_pkg::TEST_NORMAL);
        check(32'(staticReadMode), 32'h0);
        addrHit <= 1'b1;
        repeat (2) @(posedge clk);
        check(32'(ispIrq), 32'h1);
        addrHit <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'(ispIrq), 32'h0);
        $display("mode done");
        progByte(13'h0123, 8'h00, 8'h03, 1'b0);
        wbCycle(1'b1, otp_pkg::ADDR_CTRL, 8'h00);
        runIdle(1'b0, 1'b1);
        hvEnable <= 1'b1;
        repeat (250) @(posedge clk);
        readCheck(otp_pkg::ADDR_CTRL, 8'h10);
        for (int i = 0; i < 8; i++)
        begin
            a = (i == 0) ? 13'h1fff : 13'($urandom);
            repeat (2)
            begin
                d = 8'($urandom);
                progByte(a, d, 8'h03, 1'b1);
                shadow[int'(a)] = expAnd(a, d);
                verify(a, 8'h01, shadow[int'(a)]);
            end
        end
        $display("program done");
        verify(13'h0030, 8'h05, 8'ha5);
        verify(13'h0031, 8'h05, 8'h5a);
        verify(13'h0060, 8'h05, otp_pkg::ID_VAL2);
        progByte(13'h0030, 8'h00, 8'h07, 1'b0);
        readCheck(otp_pkg::ADDR_AL, 8'h30);
        verify(13'h0030, 8'h05, 8'ha5);
        $display("id done");
        end_of_test();
    end
endmodule // tb
`default_nettype wire
